/* File: src/fswd_cfg.svh */
// Constants of the fail-safe watchdog and power mode controller.
`ifndef FSWD_CFG_SVH
`define FSWD_CFG_SVH
`define FSWD_ADDR_W          4
`define FSWD_OFF_CTRL        4'h0
`define FSWD_OFF_RELOAD      4'h4
`define FSWD_OFF_POWER       4'h8
`define FSWD_OFF_STATUS      4'hC
`define FSWD_REL_SLOW        7
`define FSWD_RELOAD_RST      8'h00
`define FSWD_WD_W            15
`define FSWD_WD_TRIP         15'h7FFC
`define FSWD_PRE_FAST        5'h01
`define FSWD_PRE_SLOW        5'h1F
`define FSWD_HOLD_FAST       8'h08
`define FSWD_HOLD_SLOW       8'h80
`define FSWD_RC_RATIO        3'h5
`define FSWD_CLK_PERIOD_NS   10
`define FSWD_FINAL_PHASE_NS  1000000
`endif

/* File: src/fswd_pkg.sv */
// Types shared by the fail-safe watchdog and power mode controller.
package fswd_pkg;

  typedef enum logic [1:0] {
    WD_STOPPED = 2'b00,
    WD_COUNT   = 2'b01,
    WD_HOLD    = 2'b10
  } fswd_wd_e;

  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_IDLE   = 2'b01,
    PM_DOWN   = 2'b10
  } fswd_pm_e;

  typedef struct packed {
    logic [27:0] rsvd;
    logic        oscFlag;
    logic        wdFlag;
    logic        start;
    logic        refresh;
  } fswd_ctrl_s;

  typedef struct packed {
    logic [24:0] rsvd;
    logic        downConfirm;
    logic        sleepConfirm;
    logic [2:0]  rsvd2;
    logic        downRequest;
    logic        idleRequest;
  } fswd_power_s;

  typedef struct packed {
    logic [10:0] rsvd;
    logic        oscReset;
    logic        powerDown;
    logic        idle;
    logic        hold;
    logic        run;
    logic        pad;
    logic [14:0] count;
  } fswd_status_s;

endpackage

/* File: src/fswd_sync.sv */
// Two flip-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/10ps
module fswd_sync
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic din,
  output logic      dout
);

  logic firstStage_reg;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      firstStage_reg <= 1'b0;
      dout           <= 1'b0;
    end
    else
    begin
      firstStage_reg <= din;
      dout           <= firstStage_reg;
    end
  end

endmodule // fswd_sync

/* File: src/fswd_osc_monitor.sv */
// Oscillator monitor: compares the main oscillator against the RC reference.
`timescale 1ns/10ps
`include "fswd_cfg.svh"
module fswd_osc_monitor
  import fswd_pkg::*;
#(
  parameter int FINAL_CYCLES = 100000
)
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic oscPin,
  input  wire logic rcPin,
  input  wire logic freeze,
  output logic      clkSelRc,
  output logic      oscReset,
  output logic      mainClkDiv2
);

  localparam int CW = $clog2(FINAL_CYCLES + 1);
  localparam logic [CW-1:0] FINAL_LOAD = CW'(FINAL_CYCLES);

  logic          oscSync;
  logic          rcSync;
  logic          oscPrev_reg;
  logic          rcPrev_reg;
  logic [2:0]    rcCount_reg;
  logic [CW-1:0] final_reg;
  logic          oscRise;
  logic          rcRise;
  logic          failNext;
  logic [CW-1:0] finalNext;
  logic [2:0]    rcCountNext;

  fswd_sync oscSyncInst (.clk(clk), .rstn(rstn), .din(oscPin), .dout(oscSync));
  fswd_sync rcSyncInst  (.clk(clk), .rstn(rstn), .din(rcPin),  .dout(rcSync));

  assign oscRise = oscSync & ~oscPrev_reg & ~freeze;
  assign rcRise  = rcSync & ~rcPrev_reg & ~freeze;

  // R12: slow oscillator detect
  assign rcCountNext = oscRise ? 3'h0 :
                       (rcRise && rcCount_reg != `FSWD_RC_RATIO) ? rcCount_reg + 3'h1 :
                       rcCount_reg;
  assign failNext    = (rcCountNext == `FSWD_RC_RATIO);
  // R15: final reset phase
  assign finalNext   = failNext ? FINAL_LOAD :
                       (final_reg != '0 && !freeze) ? final_reg - CW'(1) : final_reg;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      oscPrev_reg <= 1'b0;
      rcPrev_reg  <= 1'b0;
      rcCount_reg <= 3'h0;
      final_reg   <= '0;
      clkSelRc    <= 1'b0;
      oscReset    <= 1'b0;
      mainClkDiv2 <= 1'b0;
    end
    else
    begin
      oscPrev_reg <= oscSync;
      rcPrev_reg  <= rcSync;
      rcCount_reg <= rcCountNext;
      final_reg   <= finalNext;
      // R12: switch to RC and reset
      clkSelRc    <= failNext;
      oscReset    <= failNext | (finalNext != '0);
      // R14: main oscillator halved
      if (oscRise && !failNext)
      begin
        mainClkDiv2 <= ~mainClkDiv2;
      end
    end
  end

endmodule // fswd_osc_monitor

/* File: src/fswd_top.sv */
// Software watchdog, oscillator monitor and power mode control with an APB slave.
//
// Overview of operation
// R1: Fifteen-bit up-counter stepped at machine rate over two or thirty-two.
// R2: Once started the watchdog cannot be stopped by software.
// R3: Count freezes in idle, power-down or oscillator monitor reset.
// R4: Refresh needs refresh bit then start bit in the very next write.
// R5: A valid refresh reloads the counter from the reload value.
// R6: Counter reaching 7FFCH raises the internal watchdog reset.
// R7: Watchdog reset lasts 8 cycles fast, 128 cycles slow.
// R8: After watchdog reset the watchdog keeps running and its flag sets.
// R9: External hardware reset clears the watchdog reset flag.
// R10: Software clears the watchdog reset flag by writing zero.
// R11: The oscillator monitor is always on with no disable.
// R12: Oscillator below RC over five selects RC clock and resets.
// R13: Oscillator monitor reset keeps watchdog flag and sets its own flag.
// R14: Oscillator above RC over five clocks system from oscillator over two.
// R15: After failure clears reset stays on for about one millisecond.
// R16: Idle and power-down together give power-down.
// R17: Idle needs idle bit then confirm bit; CPU gated, peripherals run.
// R18: Idle ends on an enabled interrupt or a hardware reset.
// R19: Power-down needs request then confirm; oscillators stop; reset ends it.
// R20: Outside reset ending power-down is held until the oscillator settles; here rstn ends power-down at once with no settle wait.
`timescale 1ns/10ps
`include "fswd_cfg.svh"
module fswd_top
  import fswd_pkg::*;
#(
  parameter int FINAL_CYCLES = (`FSWD_FINAL_PHASE_NS + `FSWD_CLK_PERIOD_NS - 1) /
                               `FSWD_CLK_PERIOD_NS
)
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cycleTick,
  input  wire logic        irqPending,
  input  wire logic        oscPin,
  input  wire logic        rcPin,
  output logic             sysResetOut,
  output logic             cpuGateOff,
  output logic             oscStop,
  output logic             clkSelRc,
  output logic             mainClkDiv2
);

  fswd_wd_e               wdState_reg;
  fswd_wd_e               wdState_next;
  fswd_pm_e               pmState_reg;
  fswd_pm_e               pmState_next;
  logic [`FSWD_WD_W-1:0]  count_reg;
  logic [`FSWD_WD_W-1:0]  count_next;
  logic [4:0]             pre_reg;
  logic [4:0]             pre_next;
  logic [7:0]             hold_reg;
  logic [7:0]             hold_next;
  logic [7:0]             reload_reg;
  logic                   wdFlag_reg;
  logic                   oscFlag_reg;
  logic                   refreshArm_reg;
  logic                   idleArm_reg;
  logic                   downArm_reg;
  logic                   oscReset;
  logic                   wdHold;
  logic                   freeze;
  logic                   slow;
  logic                   preLimit;
  logic                   step;
  logic                   tripHit;
  logic                   holdDone;
  logic                   setupPhase;
  logic                   wrAccess;
  logic                   wrCtrl;
  logic                   wrReload;
  logic                   wrPower;
  logic                   mapped;
  logic                   refreshValid;
  logic                   enterIdle;
  logic                   enterDown;
  logic                   internalReset;
  logic [`FSWD_WD_W-1:0]  reloadValue;
  logic [31:0]            readWord;
  fswd_ctrl_s             ctrlIn;
  fswd_power_s            powerIn;
  fswd_ctrl_s             ctrlOut;
  fswd_power_s            powerOut;
  fswd_status_s           statusOut;

  // R11: monitor has no enable
  fswd_osc_monitor #(
    .FINAL_CYCLES (FINAL_CYCLES)
  ) oscMonInst (
    .clk         (clk),
    .rstn        (rstn),
    .oscPin      (oscPin),
    .rcPin       (rcPin),
    .freeze      (oscStop),
    .clkSelRc    (clkSelRc),
    .oscReset    (oscReset),
    .mainClkDiv2 (mainClkDiv2)
  );

  // APB decode. The slave never inserts wait states; read data is caught in setup.
  assign pready     = 1'b1;
  assign setupPhase = psel & ~penable;
  assign wrAccess   = psel & penable & pwrite;
  assign mapped     = (paddr[31:`FSWD_ADDR_W] == '0) && (paddr[1:0] == 2'b00);
  assign wrCtrl     = wrAccess && mapped && (paddr[`FSWD_ADDR_W-1:0] == `FSWD_OFF_CTRL);
  assign wrReload   = wrAccess && mapped && (paddr[`FSWD_ADDR_W-1:0] == `FSWD_OFF_RELOAD);
  assign wrPower    = wrAccess && mapped && (paddr[`FSWD_ADDR_W-1:0] == `FSWD_OFF_POWER);
  assign ctrlIn     = fswd_ctrl_s'(pwdata);
  assign powerIn    = fswd_power_s'(pwdata);

  // R4: refresh pair check
  assign refreshValid = wrCtrl & ctrlIn.start & refreshArm_reg;
  // R17: idle pair check
  assign enterIdle    = wrPower & powerIn.sleepConfirm & idleArm_reg;
  // R19: power-down pair check
  assign enterDown    = wrPower & powerIn.downConfirm & downArm_reg;

  // R1: prescaler of two or thirty-two
  assign slow     = reload_reg[`FSWD_REL_SLOW];
  assign preLimit = slow ? (pre_reg == `FSWD_PRE_SLOW) : (pre_reg == `FSWD_PRE_FAST);
  // R3: freeze conditions
  assign freeze   = (pmState_reg != PM_ACTIVE) | oscReset;
  assign step     = (wdState_reg == WD_COUNT) & cycleTick & ~freeze & preLimit;
  assign tripHit  = step & (count_reg + 15'h0001 == `FSWD_WD_TRIP);
  assign holdDone = (wdState_reg == WD_HOLD) & cycleTick & (hold_reg == 8'h01);
  assign wdHold   = (wdState_reg == WD_HOLD);

  // R5: reload value layout
  assign reloadValue = {reload_reg[6:0], 8'h00};

  always_comb
  begin
    wdState_next = wdState_reg;
    count_next   = count_reg;
    pre_next     = pre_reg;
    hold_next    = hold_reg;
    unique case (wdState_reg)
      WD_STOPPED:
      begin
        if (wrCtrl && ctrlIn.start)
        begin
          wdState_next = WD_COUNT;
          count_next   = reloadValue;
          pre_next     = 5'h00;
        end
      end
      WD_COUNT:
      begin
        if (refreshValid)
        begin
          // R5: reload on refresh
          count_next = reloadValue;
          pre_next   = 5'h00;
        end
        else if (tripHit)
        begin
          // R6: trip at threshold
          wdState_next = WD_HOLD;
          count_next   = `FSWD_WD_TRIP;
          // R7: hold length by prescaler
          hold_next    = slow ? `FSWD_HOLD_SLOW : `FSWD_HOLD_FAST;
        end
        else if (cycleTick && !freeze)
        begin
          // R1: up-count by prescaler
          pre_next = preLimit ? 5'h00 : pre_reg + 5'h01;
          if (step)
          begin
            count_next = count_reg + 15'h0001;
          end
        end
      end
      WD_HOLD:
      begin
        if (holdDone)
        begin
          // R8: resume counting after reset
          wdState_next = WD_COUNT;
          count_next   = reloadValue;
          pre_next     = 5'h00;
        end
        else if (cycleTick)
        begin
          hold_next = hold_reg - 8'h01;
        end
      end
      default:
      begin
        wdState_next = WD_STOPPED;
      end
    endcase
  end

  assign internalReset = wdHold | oscReset;

  always_comb
  begin
    pmState_next = pmState_reg;
    unique case (pmState_reg)
      PM_ACTIVE:
      begin
        // R16: power-down takes precedence
        if (enterDown)
        begin
          pmState_next = PM_DOWN;
        end
        else if (enterIdle)
        begin
          pmState_next = PM_IDLE;
        end
      end
      PM_IDLE:
      begin
        // R18: idle wake sources
        if (irqPending || internalReset)
        begin
          pmState_next = PM_ACTIVE;
        end
        else if (enterDown)
        begin
          pmState_next = PM_DOWN;
        end
      end
      PM_DOWN:
      begin
        // R19: only hardware reset leaves
        pmState_next = PM_DOWN;
      end
      default:
      begin
        pmState_next = PM_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wdState_reg <= WD_STOPPED;
      pmState_reg <= PM_ACTIVE;
      count_reg   <= '0;
      pre_reg     <= 5'h00;
      hold_reg    <= 8'h00;
    end
    else
    begin
      // R2: no path back to stopped
      wdState_reg <= wdState_next;
      pmState_reg <= pmState_next;
      count_reg   <= count_next;
      pre_reg     <= pre_next;
      hold_reg    <= hold_next;
    end
  end

  // Any write breaks a pending pair, so the second write must follow at once.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      refreshArm_reg <= 1'b0;
      idleArm_reg    <= 1'b0;
      downArm_reg    <= 1'b0;
      reload_reg     <= `FSWD_RELOAD_RST;
    end
    else if (wrAccess)
    begin
      // R4: arm on refresh bit
      refreshArm_reg <= wrCtrl & ctrlIn.refresh;
      idleArm_reg    <= wrPower & powerIn.idleRequest;
      downArm_reg    <= wrPower & powerIn.downRequest;
      if (wrReload)
      begin
        reload_reg <= pwdata[7:0];
      end
    end
  end

  // Flags are cleared by the external reset pin, the watchdog flag also by software, never by internal resets.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      // R9: external reset clears flag
      wdFlag_reg  <= 1'b0;
      oscFlag_reg <= 1'b0;
    end
    else
    begin
      // R8: set wins over clear
      // R10: software clear by zero
      if (wdState_next == WD_HOLD && wdState_reg == WD_COUNT)
      begin
        wdFlag_reg <= 1'b1;
      end
      else if (wrCtrl && !ctrlIn.wdFlag)
      begin
        wdFlag_reg <= 1'b0;
      end
      // R13: monitor reset sets own flag
      if (oscReset)
      begin
        oscFlag_reg <= 1'b1;
      end
    end
  end

  assign ctrlOut   = '{rsvd: '0, oscFlag: oscFlag_reg, wdFlag: wdFlag_reg,
                       start: (wdState_reg != WD_STOPPED), refresh: refreshArm_reg};
  assign powerOut  = '{rsvd: '0, downConfirm: (pmState_reg == PM_DOWN),
                       sleepConfirm: (pmState_reg == PM_IDLE), rsvd2: '0,
                       downRequest: downArm_reg, idleRequest: idleArm_reg};
  assign statusOut = '{rsvd: '0, oscReset: oscReset, powerDown: (pmState_reg == PM_DOWN),
                       idle: (pmState_reg == PM_IDLE), hold: wdHold,
                       run: (wdState_reg == WD_COUNT), pad: 1'b0, count: count_reg};

  assign readWord = !mapped ? 32'h0000_0000 :
                    (paddr[`FSWD_ADDR_W-1:0] == `FSWD_OFF_CTRL)   ? 32'(ctrlOut) :
                    (paddr[`FSWD_ADDR_W-1:0] == `FSWD_OFF_RELOAD) ? {24'h000000, reload_reg} :
                    (paddr[`FSWD_ADDR_W-1:0] == `FSWD_OFF_POWER)  ? 32'(powerOut) :
                    32'(statusOut);

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      prdata      <= 32'h0000_0000;
      pslverr     <= 1'b0;
      sysResetOut <= 1'b0;
      cpuGateOff  <= 1'b0;
      oscStop     <= 1'b0;
    end
    else
    begin
      if (setupPhase)
      begin
        prdata  <= readWord;
        pslverr <= ~mapped;
      end
      // R12: internal reset from either source
      sysResetOut <= wdHold | oscReset;
      // R17: CPU gated in idle and power-down
      cpuGateOff  <= (pmState_next != PM_ACTIVE);
      // R19: oscillators stopped in power-down
      oscStop     <= (pmState_next == PM_DOWN);
    end
  end

endmodule // fswd_top

/* File: test/fswd_monitor.sv */
// Port checker for the watchdog and power mode block.
`timescale 1ns/10ps
`include "fswd_cfg.svh"
module fswd_monitor
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic        pslverr,
  input wire logic        irqPending,
  input wire logic        sysResetOut,
  input wire logic        cpuGateOff,
  input wire logic        oscStop,
  input wire logic        clkSelRc
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic badAddr = (paddr[31:4] != 28'h0) || (paddr[1:0] != 2'h0);
  wire logic powerWr = psel && penable && pwrite && (paddr == {28'h0, `FSWD_OFF_POWER});
  sequence sAccess;
    psel && penable;
  endsequence
  sequence sNapWake;
    cpuGateOff && !oscStop && irqPending;
  endsequence
  chk_err_unmapped: assert property ((sAccess ##0 badAddr) |-> pslverr)
    else $error("unmapped access without error");
  chk_ok_mapped: assert property ((sAccess ##0 !badAddr) |-> !pslverr)
    else $error("mapped access flagged");
  chk_gate_cause: assert property ($rose(cpuGateOff) |-> $past(powerWr))
    else $error("gate rose without power write");
  chk_down_gates: assert property (oscStop |-> cpuGateOff)
    else $error("power-down without cpu gate");
  chk_down_stays: assert property (oscStop |=> oscStop)
    else $error("power-down left without reset");
  chk_idle_wake: assert property (sNapWake |-> ##[1:3] !cpuGateOff)
    else $error("idle not left on interrupt");
  chk_fail_reset: assert property ($rose(clkSelRc) |-> ##[0:1] sysResetOut)
    else $error("clock switch without reset");
  chk_fail_holds: assert property (clkSelRc ##1 clkSelRc |-> sysResetOut)
    else $error("reset dropped during failure");
  chk_final_phase: assert property ($fell(clkSelRc) |-> sysResetOut [*8])
    else $error("final reset phase too short");
endmodule // fswd_monitor

bind fswd_top fswd_monitor u_fswd_monitor (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr),
  .irqPending(irqPending), .sysResetOut(sysResetOut), .cpuGateOff(cpuGateOff),
  .oscStop(oscStop), .clkSelRc(clkSelRc));

/* File: test/testbench.sv */
// Self-checking bench of the watchdog and power mode block.
`timescale 1ns/10ps
module testbench
  import fswd_pkg::*;
;
  logic        clk, rstn, psel, penable, pwrite, cycleTick, irqPending, oscPin, rcPin;
  logic        pready, pslverr, sysResetOut, cpuGateOff, oscStop, clkSelRc, mainClkDiv2;
  logic        oscOn, er, prev;
  logic [31:0] paddr, pwdata, prdata, rd, keep;
  logic [3:0]  rcDiv;
  int          err_count, total_checks, n, m;

  fswd_top #(.FINAL_CYCLES(20)) u_fswd_top (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cycleTick(cycleTick), .irqPending(irqPending),
    .oscPin(oscPin), .rcPin(rcPin), .sysResetOut(sysResetOut), .cpuGateOff(cpuGateOff),
    .oscStop(oscStop), .clkSelRc(clkSelRc), .mainClkDiv2(mainClkDiv2));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The RC reference runs slow and free; the main oscillator stands when switched off.
  always @(posedge clk)
  begin
    rcDiv <= rcDiv + 4'h1;
    if (rcDiv == 4'hF) rcPin <= ~rcPin;
    if (oscOn) oscPin <= ~oscPin;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  task waitRes(input logic v, input int lim);
    n = 0;
    while (sysResetOut !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    if (sysResetOut !== v)
    begin
      err_count++;
      $display("Error at %0t: reset level wait ran out", $time);
    end
  endtask

  task doReset;
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask

  task t_regs;
    apb(0, 32'hC, 0); check(rd, 32'h0);
    apb(0, 32'h10, 0); check({rd[30:0], er}, 32'h1);
    apb(1, 32'h2, 32'h2); apb(0, 32'h0, 0); check(rd, 32'h0);
    $display("test regs done");
  endtask

  task t_trip(input logic slow);
    apb(1, 32'h4, {24'h0, slow, 7'h7F});
    cycleTick <= 1'b1;
    apb(1, 32'h0, 32'h2);
    waitRes(1, 9000);
    m = slow ? 8064 : 504;
    check(n >= m - 4 && n <= m + 4, 1);
    waitRes(0, 300); check(n, slow ? 128 : 8);
    cycleTick <= 1'b0;
    apb(0, 32'h0, 0); check(rd, 32'h6);
    $display("test trip done");
  endtask

  task t_refresh;
    apb(1, 32'h0, 32'h0); apb(0, 32'h0, 0); check(rd, 32'h2);
    apb(1, 32'h0, 32'h1); apb(1, 32'h0, 32'h2);
    apb(0, 32'hC, 0); check(rd, 32'h00017F00);
    cycleTick <= 1'b1; repeat (40) @(posedge clk); cycleTick <= 1'b0;
    apb(0, 32'hC, 0); check(rd, 32'h00017F14);
    apb(1, 32'h0, 32'h1); apb(1, 32'h8, 32'h0); apb(1, 32'h0, 32'h2);
    apb(0, 32'hC, 0); check(rd, 32'h00017F14);
    apb(1, 32'h0, 32'h1); apb(1, 32'h0, 32'h2);
    apb(0, 32'hC, 0); check(rd, 32'h00017F00);
    $display("test refresh done");
  endtask

  task t_power;
    apb(1, 32'h8, 32'h1); apb(1, 32'h0, 32'h0); apb(1, 32'h8, 32'h20);
    check(cpuGateOff, 0);
    apb(1, 32'h8, 32'h1); apb(1, 32'h8, 32'h20);
    check({cpuGateOff, oscStop}, 32'h2);
    apb(0, 32'hC, 0); keep = rd;
    cycleTick <= 1'b1; repeat (20) @(posedge clk); cycleTick <= 1'b0;
    apb(0, 32'hC, 0); check(rd, keep);
    irqPending <= 1'b1; repeat (3) @(posedge clk); irqPending <= 1'b0;
    check(cpuGateOff, 0);
    apb(1, 32'h8, 32'h3); apb(1, 32'h8, 32'h60);
    check({cpuGateOff, oscStop}, 32'h3);
    irqPending <= 1'b1; repeat (5) @(posedge clk); irqPending <= 1'b0;
    check(oscStop, 1);
    doReset; check(oscStop, 0);
    $display("test power done");
  endtask

  task t_osc;
    oscOn <= 1'b0;
    waitRes(1, 400); check(clkSelRc, 1);
    apb(0, 32'h0, 0); check(rd, 32'hE);
    oscOn <= 1'b1;
    m = 0;
    while (clkSelRc !== 1'b0 && m < 100)
    begin
      @(posedge clk);
      m++;
    end
    check(clkSelRc, 0);
    waitRes(0, 100); check(n >= 19 && n <= 23, 1);
    m = 0;
    repeat (32)
    begin
      prev = mainClkDiv2;
      @(posedge clk);
      if (mainClkDiv2 !== prev) m++;
    end
    check(m, 16);
    doReset; apb(0, 32'h0, 0); check(rd, 32'h0);
    $display("test osc done");
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // A hang is cut short well after the longest expected run.
  initial
  begin
    repeat (60000) @(posedge clk);
    err_count++;
    final_report;
  end

  initial
  begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0;
    pwdata = 32'h0; cycleTick = 1'b0; irqPending = 1'b0; oscPin = 1'b0; rcPin = 1'b0;
    oscOn = 1'b1; rcDiv = 4'h0; err_count = 0; total_checks = 0;
    doReset;
    t_regs;
    t_trip(1'b0);
    t_refresh;
    t_power;
    t_trip(1'b1);
    t_osc;
    final_report;
  end
endmodule // testbench
